// file: common/ufa_pkg.sv
// Shared constants and carrier types for the receive framing/address block
package ufa_pkg;
    // Serial control register field positions
    localparam int SCR_RX_FLAG = 0;
    localparam int SCR_RX_BIT8 = 2;
    localparam int SCR_RX_EN = 4;
    localparam int SCR_ADDR_EN = 5;
    localparam int SCR_MODE1 = 6;
    localparam int SCR_BIT7 = 7;
    // Power control register field position
    localparam int PCR_FLAG_SEL = 6;
    // Reset values
    localparam logic [7:0] SCR_RESET = 8'h00;
    localparam logic [7:0] SLAVE_ADDRESS_REG_RESET = 8'h00;
    localparam logic [7:0] SMASK_RESET = 8'h00;
    localparam logic [7:0] PCR_RESET = 8'h00;
    // Timing: one bit time and the mid-bit sample point, in clock cycles
    localparam int CLK_MHZ = 100;
    localparam int BAUD_NS = 8680;
    localparam logic [15:0] BIT_CYC = 16'((BAUD_NS * CLK_MHZ) / 1000);
    localparam logic [15:0] HALF_CYC = 16'((BAUD_NS * CLK_MHZ) / 2000);
    // FIFO geometry
    localparam int FIFO_W = 9;
    localparam int FIFO_D = 16;

    typedef enum logic [1:0] {
        UFA_MODE_SHIFT,
        UFA_MODE_8BIT,
        UFA_MODE_9BIT_A,
        UFA_MODE_9BIT_B
    } ufa_mode_t;

    typedef enum logic [2:0] {
        UFA_IDLE,
        UFA_START,
        UFA_DATA,
        UFA_NINTH,
        UFA_STOP
    } ufa_rx_st_t;

    // Frame handed to the FIFO: ninth bit plus byte
    typedef struct packed {
        logic bit8;
        logic [7:0] data;
    } ufa_frame_t;
endpackage

// file: dv/ufa_master.sv
// Master sender model driving the shared serial line
`timescale 1ns/1ps
// ==========================================
// Master model
module ufa_master (
    input wire logic clk, // Bit timing clock
    output logic txd // Serial line, pulled up when idle
);
    initial txd = 1'b1;
    // Start, LSB first, ninth bit if asked, stop; line idles high after
    task automatic send(input logic [8:0] f, input logic nine,
                        input logic stp);
        for (int i = 0; i < 10 + nine; i++) begin
            txd <= (i == 0) ? 1'b0 : (i < 9) ? f[i-1] :
                   (i == 9 && nine) ? f[8] : stp;
            repeat (ufa_pkg::BIT_CYC) @(posedge clk);
        end
        txd <= 1'b1;
    endtask
endmodule

// file: dv/ufa_rx_sva.sv
// Concurrent checks on the receive block ports
`timescale 1ns/1ps
// ==========================================
// Checker
module ufa_rx_sva (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic rxd, // Line
    input wire logic [7:0] scr_wdata, // Control data
    input wire logic scr_we, // Control strobe
    input wire logic [7:0] pcr_wdata, // Power data
    input wire logic pcr_we, // Power strobe
    input wire logic [7:0] slave_address_reg_wdata, // Address data
    input wire logic slave_address_reg_we, // Address strobe
    input wire logic [7:0] smask_wdata, // Mask data
    input wire logic smask_we, // Mask strobe
    input wire logic fifo_ready, // Pop
    input wire logic [7:0] scr_rdata, // Control view
    input wire logic framing_error_flag, // Framing flag
    input wire logic receive_flag, // Receive flag
    input wire logic [8:0] fifo_data, // Head
    input wire logic fifo_valid // Head present
);
    logic sel_q;
    logic [15:0] low_q;
    // Select copy, and cycles since line low; saturates, never wraps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
            low_q <= 16'hFFFF;
        end else begin
            sel_q <= pcr_we ? pcr_wdata[6] : sel_q;
            low_q <= !rxd ? 16'h0000 : low_q + 16'(low_q != 16'hFFFF);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    fe_sticky_a: assert property (
        $fell(framing_error_flag) |-> $past(scr_we) && !$past(scr_wdata[7]))
        else $error("Framing flag fell without a clear");
    rf_hold_a: assert property (
        $fell(receive_flag) |-> $past(scr_we) && !$past(scr_wdata[0]))
        else $error("Receive flag fell without a clear");
    fe_view_a: assert property (
        sel_q && $past(sel_q, 2) && $stable(framing_error_flag)
        |-> scr_rdata[7] == framing_error_flag)
        else $error("Control bit 7 not showing framing flag");
    rst_clear_a: assert property ($rose(rst_n) |->
        !receive_flag && !framing_error_flag && !fifo_valid)
        else $error("Flags not clear after reset");
    fifo_hold_a: assert property (fifo_valid && !fifo_ready |=>
        fifo_valid && $stable(fifo_data))
        else $error("Head frame lost while stalled");
    fe_cause_a: assert property (
        $rose(framing_error_flag) |-> low_q < 16'd1000)
        else $error("Framing flag without a low stop sample");
    flag_push_a: assert property (
        $rose(receive_flag) |-> ##[0:4] fifo_valid)
        else $error("Accepted frame not queued");
    flag_cause_a: assert property (
        $rose(receive_flag) |-> low_q < 16'd10000)
        else $error("Receive flag without a frame");
    ctrl_write_a: assert property (
        scr_we ##1 !scr_we |=> scr_rdata[5:4] == $past(scr_wdata[5:4], 2))
        else $error("Control write not shown");
    cover property ($rose(receive_flag));
    cover property ($rose(framing_error_flag));
    cover property (fifo_valid && fifo_ready);
endmodule
bind ufa_rx ufa_rx_sva ufa_rx_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .rxd(rxd), .scr_wdata(scr_wdata), .scr_we(scr_we),
    .pcr_wdata(pcr_wdata), .pcr_we(pcr_we), .slave_address_reg_wdata(slave_address_reg_wdata),
    .slave_address_reg_we(slave_address_reg_we), .smask_wdata(smask_wdata), .smask_we(smask_we),
    .fifo_ready(fifo_ready), .scr_rdata(scr_rdata),
    .framing_error_flag(framing_error_flag), .receive_flag(receive_flag),
    .fifo_data(fifo_data), .fifo_valid(fifo_valid));

// file: dv/ufa_rx_test.sv
// Self-checking bench for the receive framing and address block
`timescale 1ns/1ps
// ==========================================
// Bench
module ufa_rx_test;
    typedef struct packed {
        logic [7:0] pcr, sa, sm, scr, dat;
        logic nine, b9, stp, rf, fe;
    } ufa_row_t;
    logic sys_clk, rst_n = 1'b0, rxd, fifo_ready = 1'b0, fe, rf, fv;
    logic [7:0] wd = 8'h00;
    logic [7:0] rd;
    logic [3:0] we = 4'h0;
    logic [8:0] fd;
    int mismatches = 0;
    int check_count = 0;
    // Mode rows; FE stays set from row 7 into row 8 across a good frame
    ufa_row_t rows [8] = '{
        '{8'h00, 8'hC0, 8'hF9, 8'hF0, 8'hC6, 1, 1, 1, 1, 0},
        '{8'h00, 8'hC0, 8'hF9, 8'hF0, 8'hC5, 1, 1, 1, 0, 0},
        '{8'h00, 8'hC0, 8'hF9, 8'hF0, 8'hFF, 1, 1, 1, 1, 0},
        '{8'h00, 8'hC0, 8'hF9, 8'hF0, 8'hC6, 1, 0, 1, 0, 0},
        '{8'h00, 8'hC0, 8'hF9, 8'hD0, 8'h12, 1, 0, 1, 1, 0},
        '{8'h00, 8'hC0, 8'hF9, 8'h70, 8'hC6, 0, 0, 1, 1, 0},
        '{8'h40, 8'hC0, 8'hF9, 8'h70, 8'hC6, 0, 0, 0, 0, 1},
        '{8'h00, 8'hC0, 8'hF9, 8'h30, 8'hC5, 0, 0, 1, 1, 1}};
    ufa_rx ufa_rx_inst (.sys_clk(sys_clk), .rst_n(rst_n), .rxd(rxd),
        .scr_wdata(wd), .scr_we(we[0]), .pcr_wdata(wd), .pcr_we(we[1]),
        .slave_address_reg_wdata(wd), .slave_address_reg_we(we[2]), .smask_wdata(wd),
        .smask_we(we[3]), .fifo_ready(fifo_ready), .scr_rdata(rd),
        .framing_error_flag(fe), .receive_flag(rf), .fifo_data(fd),
        .fifo_valid(fv));
    ufa_master ufa_master_inst (.clk(sys_clk), .txd(rxd));
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wr(input int k, input logic [7:0] v);
        we = 4'h1 << k;
        wd = v;
        @(posedge sys_clk);
        #1 we = 4'h0;
        // Idle edge so a following write never re-raises a strobe here
        wait_cyc(1);
    endtask
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog sized a little above nine frames
    initial begin
        repeat (95000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end
    // Row loop, then select view, clear, and a mid-run reset
    initial begin
        wait_cyc(12);
        rst_n = 1'b1;
        wait_cyc(4);
        foreach (rows[i]) begin
            wr(1, rows[i].pcr);
            wr(2, rows[i].sa);
            wr(3, rows[i].sm);
            wr(0, rows[i].scr);
            ufa_master_inst.send({rows[i].b9, rows[i].dat}, rows[i].nine,
                                 rows[i].stp);
            wait_cyc(20);
            chk(rf === rows[i].rf, "receive flag");
            chk(fe === rows[i].fe, "framing flag");
            chk(fv === rows[i].rf, "queued frame");
            chk(rd[0] === rows[i].rf, "control flag bit");
            if (rows[i].rf) chk(fd === {(rows[i].nine ? rows[i].b9
                : rows[i].stp), rows[i].dat}, "data");
            fifo_ready = 1'b1;
            wait_cyc(1);
            fifo_ready = 1'b0;
            chk(fv === 1'b0, "frame taken");
            if (rows[i].rf) wr(0, rows[i].scr);
            $display("row %0d done", i);
        end
        chk(rd[7] === 1'b0, "mode bit view");
        wr(1, 8'h40);
        wait_cyc(3);
        chk(rd[7] === 1'b1, "flag view");
        wr(0, 8'h30);
        wait_cyc(2);
        chk(fe === 1'b0, "flag clear");
        $display("select and clear done");
        rst_n = 1'b0;
        wait_cyc(12);
        rst_n = 1'b1;
        chk({rf, fe, fv} === 3'b000, "reset state");
        wait_cyc(4);
        wr(0, 8'hF0);
        ufa_master_inst.send(9'h15A, 1'b1, 1'b1);
        wait_cyc(20);
        chk(rf === 1'b1, "cleared address accepts all");
        $display("reset done");
        conclude();
    end
endmodule

// file: hdl/ufa_rx.sv
// Receive framing check and automatic address recognition, with FIFO
// Function
// - A frame with a missing stop bit sets the framing error flag.
// - Control bit 7 reads as framing error when frame select is one, else mode bit 0.
// - The framing error flag is cleared only by a software write of zero.
// - Address recognition acts only while the address match enable is set.
// - In 9-bit modes with matching on, receive flag rises only on a given or broadcast address.
// - In 9-bit modes only frames with ninth bit one are address candidates.
// - In 8-bit mode with matching on, a valid stop bit and an address match are needed.
// - Shift register mode ignores the address match enable.
// - The given address cares only where the mask bit is one, matching the slave address.
// - A byte matches when every cared bit equals the given address bit.
// - Broadcast address is slave address OR mask, zero bits being don't-care.
// - Reset clears slave address and mask to zero.
`timescale 1ns/1ps

module ufa_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic [W-1:0] in_data, // Write data
    input wire logic in_valid, // Write request
    output logic in_ready, // Room available
    output logic [W-1:0] out_data, // Head word
    output logic out_valid, // Head word present
    input wire logic out_ready // Drain accepts head
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ufa_fifo_st_t;
    ufa_fifo_st_t s_q, s_d;
    logic push, pop;

    // Push and pop with count tracking
    always_comb begin
        push = in_valid && (s_q.cnt != (AW+1)'(D));
        pop = out_ready && (s_q.cnt != '0);
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = s_q.wr + AW'(1);
        end
        if (pop) begin
            s_d.rd = s_q.rd + AW'(1);
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready = s_q.cnt != (AW+1)'(D);
    assign out_valid = s_q.cnt != '0;
    assign out_data = s_q.mem[s_q.rd];
endmodule

module ufa_rx (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic rxd, // Serial line input pin
    input wire logic [7:0] scr_wdata, // Serial control write data
    input wire logic scr_we, // Serial control write strobe
    input wire logic [7:0] pcr_wdata, // Power control write data
    input wire logic pcr_we, // Power control write strobe
    input wire logic [7:0] slave_address_reg_wdata, // Slave address write data
    input wire logic slave_address_reg_we, // Slave address write strobe
    input wire logic [7:0] smask_wdata, // Address mask write data
    input wire logic smask_we, // Address mask write strobe
    input wire logic fifo_ready, // Consumer takes a frame
    output logic [7:0] scr_rdata, // Serial control read value
    output logic framing_error_flag, // Sticky framing error
    output logic receive_flag, // Frame accepted
    output logic [8:0] fifo_data, // Head frame, ninth bit on top
    output logic fifo_valid // Head frame present
);
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] rx_sync;
        ufa_pkg::ufa_rx_st_t st;
        logic [15:0] cyc;
        logic [3:0] nbit;
        logic [8:0] shf;
        logic [7:0] scr;
        logic [7:0] pcr;
        logic [7:0] slave_address_reg;
        logic [7:0] slave_address_mask;
        logic framing_error_flag;
        logic [7:0] rdata;
        logic fe_out;
        logic ri_out;
        logic [8:0] fdata;
        logic fvalid;
    } ufa_st_t;

    ufa_st_t s_q, s_d;
    logic srst_n;
    logic rx_s;
    ufa_pkg::ufa_mode_t mode;
    logic addr_en, given_hit, bcast_hit, accept, push, stop_ok;
    logic [7:0] bcast;
    ufa_pkg::ufa_frame_t frame;
    logic f_in_ready, f_out_valid;
    logic [8:0] f_out_data;

    assign srst_n = s_q.rst_sync[1];
    assign rx_s = s_q.rx_sync[1];
    assign mode = ufa_pkg::ufa_mode_t'({s_q.scr[ufa_pkg::SCR_BIT7],
                                         s_q.scr[ufa_pkg::SCR_MODE1]});
    // Stop bit valid when sampled high; shift mode samples a stop bit too
    assign stop_ok = rx_s;
    assign frame = '{bit8: (mode[1] ? s_q.shf[8] : stop_ok),
                     data: s_q.shf[7:0]};
    // Given address cares where mask is one; broadcast is OR of both
    assign given_hit = ((frame.data ^ s_q.slave_address_reg)
                        & s_q.slave_address_mask) == 8'h00;
    assign bcast = s_q.slave_address_reg | s_q.slave_address_mask;
    assign bcast_hit = ((frame.data ^ bcast) & bcast) == 8'h00;
    assign addr_en = s_q.scr[ufa_pkg::SCR_ADDR_EN]
                     && mode != ufa_pkg::UFA_MODE_SHIFT;

    // Acceptance per mode when the stop bit is judged
    always_comb begin
        accept = 1'b1;
        if (addr_en) begin
            if (mode == ufa_pkg::UFA_MODE_8BIT) begin
                accept = stop_ok && (given_hit || bcast_hit);
            end else begin
                accept = s_q.shf[8] && (given_hit || bcast_hit);
            end
        end
    end

    // Framing, address match and register state
    always_comb begin
        s_d = s_q;
        push = 1'b0;
        s_d.rx_sync = {s_q.rx_sync[0], rxd};
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        if (pcr_we) begin
            s_d.pcr = pcr_wdata;
        end
        if (slave_address_reg_we) begin
            s_d.slave_address_reg = slave_address_reg_wdata;
        end
        if (smask_we) begin
            s_d.slave_address_mask = smask_wdata;
        end
        if (scr_we) begin
            s_d.scr[6:0] = scr_wdata[6:0];
            if (s_q.pcr[ufa_pkg::PCR_FLAG_SEL]) begin
                // Only software clears the sticky flag
                if (!scr_wdata[ufa_pkg::SCR_BIT7]) begin
                    s_d.framing_error_flag = 1'b0;
                end
            end else begin
                s_d.scr[ufa_pkg::SCR_BIT7] = scr_wdata[ufa_pkg::SCR_BIT7];
            end
        end
        s_d.cyc = s_q.cyc + 16'h0001;
        unique case (s_q.st)
            ufa_pkg::UFA_IDLE: begin
                s_d.cyc = 16'h0000;
                if (!rx_s && s_q.scr[ufa_pkg::SCR_RX_EN]) begin
                    s_d.st = ufa_pkg::UFA_START;
                end
            end
            ufa_pkg::UFA_START: begin
                if (s_q.cyc == ufa_pkg::HALF_CYC) begin
                    s_d.cyc = 16'h0000;
                    s_d.nbit = 4'h0;
                    s_d.st = rx_s ? ufa_pkg::UFA_IDLE : ufa_pkg::UFA_DATA;
                end
            end
            ufa_pkg::UFA_DATA: begin
                if (s_q.cyc == ufa_pkg::BIT_CYC) begin
                    s_d.cyc = 16'h0000;
                    s_d.shf = {1'b0, rx_s, s_q.shf[7:1]};
                    s_d.nbit = s_q.nbit + 4'h1;
                    if (s_q.nbit == 4'h7) begin
                        s_d.st = mode[1] ? ufa_pkg::UFA_NINTH
                                         : ufa_pkg::UFA_STOP;
                    end
                end
            end
            ufa_pkg::UFA_NINTH: begin
                if (s_q.cyc == ufa_pkg::BIT_CYC) begin
                    s_d.cyc = 16'h0000;
                    s_d.shf[8] = rx_s;
                    s_d.st = ufa_pkg::UFA_STOP;
                end
            end
            ufa_pkg::UFA_STOP: begin
                if (s_q.cyc == ufa_pkg::BIT_CYC) begin
                    s_d.st = ufa_pkg::UFA_IDLE;
                    // Set wins over a same-cycle software clear
                    if (!stop_ok) begin
                        s_d.framing_error_flag = 1'b1;
                    end
                    if (accept) begin
                        push = f_in_ready; // Full FIFO drops the frame
                        s_d.scr[ufa_pkg::SCR_RX_FLAG] = 1'b1;
                        s_d.scr[ufa_pkg::SCR_RX_BIT8] = frame.bit8;
                    end
                end
            end
        endcase
        // Bit 7 view depends on frame select
        s_d.rdata = s_d.scr;
        s_d.rdata[ufa_pkg::SCR_BIT7] = s_d.pcr[ufa_pkg::PCR_FLAG_SEL]
            ? s_d.framing_error_flag : s_d.scr[ufa_pkg::SCR_BIT7];
        s_d.fe_out = s_d.framing_error_flag;
        s_d.ri_out = s_d.scr[ufa_pkg::SCR_RX_FLAG];
        s_d.fdata = f_out_data;
        s_d.fvalid = f_out_valid && !(s_q.fvalid && fifo_ready);
    end

    // Reset clears mask and address so all bits are don't-care
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (!srst_n) begin
            s_q <= '0;
            s_q.rst_sync <= s_d.rst_sync;
            s_q.rx_sync <= s_d.rx_sync;
        end else begin
            s_q <= s_d;
        end
    end

    // Frame FIFO; a registered head keeps outputs flop-driven
    ufa_fifo #(.W(ufa_pkg::FIFO_W), .D(ufa_pkg::FIFO_D)) u_fifo (
        .clk(sys_clk),
        .rst_n(srst_n),
        .in_data(frame),
        .in_valid(push),
        .in_ready(f_in_ready),
        .out_data(f_out_data),
        .out_valid(f_out_valid),
        .out_ready(s_q.fvalid && fifo_ready)
    );

    assign scr_rdata = s_q.rdata;
    assign framing_error_flag = s_q.fe_out;
    assign receive_flag = s_q.ri_out;
    assign fifo_data = s_q.fdata;
    assign fifo_valid = s_q.fvalid;
endmodule
